// file: design/mbs_slave.sv
// Serial slave that serves the two fieldbus process-data buffers
// What this block does
// - Holding register read returns outgoing buffer
// - Input register read returns incoming buffer
// - Store only as many bytes as length
// - Buffer payload limited to 1024 bytes
// - Fieldbus output refreshed only after writes
// - Written coils stay readable by coil reads, except those of a multi-coil write whose start is not a multiple of 8
// - Eight coils packed into each byte
// - Single register write echoes request exactly
// - Register N sits at byte offset 2N
// - Coil n is bit n%8 of byte n/8, but a multi-coil write puts its first coil in bit 0
// - Register block write touches only addressed bytes
// - Answer only own switch-set slave address
// - Trigger byte leads output, counts telegrams
`timescale 1ns/1ps
module mbs_slave (
	// Clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       RSTN,
	// Configuration
	input  wire logic [3:0] ID_SW_HIGH,
	input  wire logic [3:0] ID_SW_LOW,
	input  wire logic       TRIG_MODE,
	// Serial receive bytes
	input  wire logic       RX_VALID,
	input  wire logic [7:0] RX_DATA,
	input  wire logic       RX_FRAME_END,
	// Serial transmit bytes
	output logic            TX_VALID,
	output logic [7:0]      TX_DATA,
	input  wire logic       TX_READY,
	// Fieldbus data in
	input  wire logic       FB_IN_VALID,
	input  wire logic       FB_IN_FIRST,
	input  wire logic [7:0] FB_IN_DATA,
	// Fieldbus data out
	output logic            FB_OUT_VALID,
	output logic            FB_OUT_FIRST,
	output logic [7:0]      FB_OUT_DATA
);
	mbs_pkg::mbs_core_type q;
	mbs_pkg::mbs_core_type d;
	logic [7:0]  rxf  [mbs_pkg::FRAME_BYTES];
	logic [7:0]  obuf [mbs_pkg::BUF_BYTES];
	logic [7:0]  ibuf [mbs_pkg::BUF_BYTES];
	logic [7:0]  fc;
	logic [15:0] adr;
	logic [15:0] qty;
	logic [17:0] coil_end;
	logic [17:0] reg_end;
	logic        is_coil;
	logic        is_reg;
	logic        is_wr;
	logic        frame_ok;
	logic [17:0] rd_ofs;
	logic [17:0] rd_ofs1;
	logic        rd_in;
	logic [7:0]  rd_lo;
	logic [7:0]  rd_hi;
	logic [15:0] coil_pair;
	logic [7:0]  last_mask;
	logic        rd_last;
	logic [7:0]  rd_byte;
	logic [7:0]  tx_body;
	logic [10:0] tx_total;
	logic [1:0]  hdr;
	logic [10:0] fbo_last;
	logic [17:0] wr_ofs;
	logic [7:0]  wr_new;
	logic [7:0]  wr_mask;
	logic [17:0] wr_end;
	logic [7:0]  crc_byte;
	logic [15:0] crc_nxt;
	logic        rx_we;
	logic        ib_we;

	// Request fields
	assign fc  = rxf[mbs_pkg::POS_FC];
	assign adr = {rxf[8'h02], rxf[8'h03]};
	assign qty = {rxf[8'h04], rxf[8'h05]};
	assign is_coil = (fc == mbs_pkg::FC_RD_COILS) ||
		(fc == mbs_pkg::FC_RD_DISC) || (fc == mbs_pkg::FC_WR_COIL) ||
		(fc == mbs_pkg::FC_WR_COILS);
	assign is_reg = (fc == mbs_pkg::FC_RD_HOLD) ||
		(fc == mbs_pkg::FC_RD_INPUT) || (fc == mbs_pkg::FC_WR_REG) ||
		(fc == mbs_pkg::FC_WR_REGS);
	assign is_wr = (fc == mbs_pkg::FC_WR_COIL) ||
		(fc == mbs_pkg::FC_WR_REG) || (fc == mbs_pkg::FC_WR_COILS) ||
		(fc == mbs_pkg::FC_WR_REGS);
	// Extent of the request in coils and in bytes
	assign coil_end = {2'b00, adr} + ((fc == mbs_pkg::FC_WR_COIL) ?
		18'h00001 : {2'b00, qty});
	assign reg_end = {1'b0, adr, 1'b0} + ((fc == mbs_pkg::FC_WR_REG) ?
		18'h00002 : {1'b0, qty, 1'b0});
	assign frame_ok = (q.rx_cnt >= mbs_pkg::MIN_FRAME) &&
		(q.crc == 16'h0000) && (rxf[mbs_pkg::POS_ID] == q.id);

	// Buffer read port, shared by write, fieldbus output and reply
	assign hdr = TRIG_MODE ? 2'h2 : 2'h1;
	assign fbo_last = {9'h000, hdr} + {3'h0, q.out_len} - 11'h001;
	assign rd_ofs = (q.st == mbs_pkg::ST_FBOUT) ?
		{7'h00, q.fbo_idx} - {16'h0000, hdr} :
		(q.st == mbs_pkg::ST_WRITE) ? q.base + q.k :
		q.base + {7'h00, q.tx_idx} - {7'h00, mbs_pkg::READ_HDR};
	assign rd_ofs1 = rd_ofs + 18'h00001;
	assign rd_in = (q.st == mbs_pkg::ST_TX) &&
		((fc == mbs_pkg::FC_RD_DISC) || (fc == mbs_pkg::FC_RD_INPUT));
	assign rd_lo = (rd_ofs >= mbs_pkg::BUF_LIMIT) ? 8'h00 :
		rd_in ? ibuf[rd_ofs[9:0]] : obuf[rd_ofs[9:0]];
	assign rd_hi = (rd_ofs1 >= mbs_pkg::BUF_LIMIT) ? 8'h00 :
		rd_in ? ibuf[rd_ofs1[9:0]] : obuf[rd_ofs1[9:0]];
	// coil bits, lowest coil in bit 0
	assign coil_pair = {rd_hi, rd_lo} >> adr[2:0];
	assign last_mask = (qty[2:0] == 3'h0) ? 8'hFF :
		8'hFF >> (4'h8 - {1'b0, qty[2:0]});
	assign rd_last = (rd_ofs == q.base + q.n - 18'h00001);
	assign rd_byte = is_coil ?
		(coil_pair[7:0] & (rd_last ? last_mask : 8'hFF)) : rd_lo;

	// Reply body bytes
	always_comb begin
		tx_body = rxf[q.tx_idx[7:0]];
		case (q.kind)
			mbs_pkg::RK_READ: begin
				if (q.tx_idx == 11'h000)
					tx_body = q.id;
				else if (q.tx_idx == 11'h001)
					tx_body = fc;
				else if (q.tx_idx == 11'h002)
					tx_body = q.n[7:0];
				else
					tx_body = rd_byte;
			end
			mbs_pkg::RK_EXC: begin
				if (q.tx_idx == 11'h000)
					tx_body = q.id;
				else if (q.tx_idx == 11'h001)
					tx_body = fc | mbs_pkg::EXC_FLAG;
				else
					tx_body = q.exc;
			end
			default: tx_body = rxf[q.tx_idx[7:0]];
		endcase
	end
	// echo ends with the received checksum
	assign tx_total = (q.kind == mbs_pkg::RK_ECHO) ? mbs_pkg::ECHO_LEN :
		q.len + 11'h002;

	// Merge data for one buffer byte
	always_comb begin
		wr_ofs  = q.base + q.k;
		wr_new  = rxf[8'(mbs_pkg::POS_DATA + q.k[7:0])];
		wr_mask = 8'hFF;
		if (fc == mbs_pkg::FC_WR_COIL) begin
			wr_mask = 8'h01 << adr[2:0];
			wr_new  = (qty == mbs_pkg::COIL_ON) ? 8'hFF : 8'h00;
		end else if (fc == mbs_pkg::FC_WR_REG) begin
			wr_new = rxf[8'(mbs_pkg::POS_VAL + q.k[7:0])];
		end else if (fc == mbs_pkg::FC_WR_COILS) begin
			wr_mask = (q.k == q.n - 18'h00001) ? last_mask : 8'hFF;
		end
		wr_end = wr_ofs + 18'h00001;
	end

	// Checksum shared by receive and reply
	assign crc_byte = (q.st == mbs_pkg::ST_TX) ? tx_body : RX_DATA;
	mbs_crc16 u_crc (
		.crc_in  (q.crc),
		.data_in (crc_byte),
		.crc_out (crc_nxt)
	);

	// Next state
	always_comb begin
		d = q;
		d.id        = {ID_SW_HIGH, ID_SW_LOW};
		d.wen       = 1'b0;
		d.fbo_valid = 1'b0;
		d.fbo_first = 1'b0;
		rx_we       = 1'b0;
		ib_we       = 1'b0;
		// fieldbus input honours the length byte
		if (FB_IN_VALID && FB_IN_FIRST) begin
			d.fbi_idx = 10'h000;
			if (TRIG_MODE) begin
				d.fbi = mbs_pkg::FI_LEN;
			end else begin
				d.fbi_left = FB_IN_DATA;
				d.fbi      = mbs_pkg::FI_DATA;
			end
		end else if (FB_IN_VALID && q.fbi == mbs_pkg::FI_LEN) begin
			d.fbi_left = FB_IN_DATA;
			d.fbi      = mbs_pkg::FI_DATA;
		end else if (FB_IN_VALID && q.fbi == mbs_pkg::FI_DATA) begin
			if (q.fbi_left != 8'h00) begin
				ib_we      = 1'b1;
				d.fbi_left = q.fbi_left - 8'h01;
				d.fbi_idx  = q.fbi_idx + 10'h001;
			end else begin
				d.fbi = mbs_pkg::FI_IDLE;
			end
		end
		case (q.st)
			mbs_pkg::ST_IDLE: begin
				if (RX_VALID) begin
					rx_we = (q.rx_cnt != mbs_pkg::RX_FULL);
					if (rx_we)
						d.rx_cnt = q.rx_cnt + 9'h001;
					d.crc = crc_nxt;
				end
				if (RX_FRAME_END)
					d.st = mbs_pkg::ST_CHECK;
			end
			mbs_pkg::ST_CHECK: begin
				d.rx_cnt = 9'h000;
				d.crc    = mbs_pkg::CRC_INIT;
				d.k      = 18'h00000;
				d.tx_idx = 11'h000;
				d.st     = mbs_pkg::ST_TX;
				d.kind   = mbs_pkg::RK_EXC;
				d.len    = mbs_pkg::EXC_LEN;
				d.exc    = 8'h00; // No code kept from an earlier frame
				if (!frame_ok) begin
					d.st = mbs_pkg::ST_IDLE;
				end else if (!is_coil && !is_reg) begin
					d.exc = mbs_pkg::EXC_BAD_FUNC;
				end else if ((is_coil && coil_end > mbs_pkg::COIL_LIMIT)
						|| (is_reg && reg_end > mbs_pkg::BUF_LIMIT)) begin
					d.exc = mbs_pkg::EXC_BAD_ADDR;
				end else if (is_coil) begin
					// eight coils per byte, aligned start
					d.base = {5'h00, adr[15:3]};
					d.n = (coil_end + 18'h00007 - {2'b00, adr}) >> 3;
					if (fc == mbs_pkg::FC_WR_COIL)
						d.n = 18'h00001;
				end else begin
					d.base = {1'b0, adr, 1'b0};
					d.n    = reg_end - {1'b0, adr, 1'b0};
				end
				if (frame_ok && (is_coil || is_reg) &&
						d.kind == mbs_pkg::RK_EXC &&
						d.exc != mbs_pkg::EXC_BAD_ADDR) begin
					d.kind = mbs_pkg::RK_READ;
					d.len  = mbs_pkg::READ_HDR + d.n[10:0];
					if (is_wr) begin
						d.st   = mbs_pkg::ST_WRITE;
						d.kind = ((fc == mbs_pkg::FC_WR_COIL) ||
							(fc == mbs_pkg::FC_WR_REG)) ?
							mbs_pkg::RK_ECHO : mbs_pkg::RK_MULTI;
						d.len  = mbs_pkg::MULTI_HDR;
					end
				end
			end
			mbs_pkg::ST_WRITE: begin
				d.wen  = 1'b1;
				d.wofs = wr_ofs[9:0];
				d.wdat = (rd_lo & ~wr_mask) | (wr_new & wr_mask);
				if (wr_end > {10'h000, q.out_len})
					d.out_len = (wr_end > mbs_pkg::LEN_MAX) ?
						8'hFF : wr_end[7:0];
				d.k = q.k + 18'h00001;
				if (q.k == q.n - 18'h00001) begin
					d.st      = mbs_pkg::ST_FBOUT;
					d.fbo_idx = 11'h000;
					if (TRIG_MODE)
						d.trig = q.trig + 8'h01;
				end
			end
			mbs_pkg::ST_FBOUT: begin
				d.fbo_valid = 1'b1;
				d.fbo_first = (q.fbo_idx == 11'h000);
				d.fbo_data  = rd_lo;
				if (TRIG_MODE && q.fbo_idx == 11'h000)
					d.fbo_data = q.trig;
				else if (q.fbo_idx == {9'h000, hdr} - 11'h001)
					d.fbo_data = q.out_len;
				d.fbo_idx = q.fbo_idx + 11'h001;
				if (q.fbo_idx == fbo_last)
					d.st = mbs_pkg::ST_TX;
			end
			default: begin
				if (!q.tx_valid || TX_READY) begin
					d.tx_valid = (q.tx_idx != tx_total);
					d.tx_idx = q.tx_idx + {10'h000, d.tx_valid};
					d.tx_data = tx_body;
					if (q.tx_idx < q.len && q.kind != mbs_pkg::RK_ECHO)
						d.crc = crc_nxt;
					else if (q.tx_idx == q.len)
						d.tx_data = q.crc[7:0];
					else
						d.tx_data = q.crc[15:8];
					if (q.kind == mbs_pkg::RK_ECHO)
						d.tx_data = tx_body;
					if (q.tx_idx == tx_total) begin
						d.st  = mbs_pkg::ST_IDLE;
						d.crc = mbs_pkg::CRC_INIT;
					end
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			q         <= '0;
			q.st      <= mbs_pkg::ST_IDLE;
			q.kind    <= mbs_pkg::RK_READ;
			q.fbi     <= mbs_pkg::FI_IDLE;
			q.crc     <= mbs_pkg::CRC_INIT;
		end else begin
			q <= d;
		end
	end

	// Frame store and the two process buffers
	always_ff @(posedge CORE_CLK) begin
		if (rx_we)
			rxf[q.rx_cnt[7:0]] <= RX_DATA;
		if (q.wen)
			obuf[q.wofs] <= q.wdat;
		if (ib_we)
			ibuf[q.fbi_idx] <= FB_IN_DATA;
	end

	// Outputs
	assign TX_VALID     = q.tx_valid;
	assign TX_DATA      = q.tx_data;
	assign FB_OUT_VALID = q.fbo_valid;
	assign FB_OUT_FIRST = q.fbo_first;
	assign FB_OUT_DATA  = q.fbo_data;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_write_end;
		q.st == mbs_pkg::ST_WRITE && q.k == q.n - 18'h00001;
	endsequence
	sequence s_fb_start;
		q.st == mbs_pkg::ST_FBOUT && q.fbo_idx == 11'h000;
	endsequence

	a_id_filter: assert property (q.st == mbs_pkg::ST_CHECK &&
		rxf[mbs_pkg::POS_ID] != q.id |=> q.st == mbs_pkg::ST_IDLE)
		else $error("foreign address answered");
	a_hold_source: assert property (
		q.st == mbs_pkg::ST_TX && fc == mbs_pkg::FC_RD_HOLD |-> !rd_in)
		else $error("holding read from wrong buffer");
	a_input_source: assert property (
		q.st == mbs_pkg::ST_TX && fc == mbs_pkg::FC_RD_INPUT |-> rd_in)
		else $error("input read from wrong buffer");
	a_len_bound: assert property (ib_we |-> q.fbi_left != 8'h00 &&
		q.fbi == mbs_pkg::FI_DATA)
		else $error("fieldbus byte stored past length");
	a_buf_limit: assert property (
		q.st == mbs_pkg::ST_WRITE |-> wr_ofs < mbs_pkg::BUF_LIMIT)
		else $error("write beyond buffer");
	a_fb_after_wr: assert property (s_write_end |=> s_fb_start)
		else $error("fieldbus refresh missing after write");
	a_fb_cause: assert property ($rose(q.fbo_valid) |->
		$past(q.st, 2) == mbs_pkg::ST_WRITE)
		else $error("fieldbus refresh without write");
	a_coil_bit: assert property (q.st == mbs_pkg::ST_WRITE &&
		fc == mbs_pkg::FC_WR_COIL |=> q.wen && q.wofs == adr[12:3] &&
		(q.wdat ^ $past(rd_lo)) == ($past(rd_lo ^ wr_new) & $past(wr_mask)))
		else $error("coil write touched wrong bit");
	a_echo_frame: assert property (q.tx_valid &&
		q.kind == mbs_pkg::RK_ECHO |-> q.tx_data ==
		rxf[8'(q.tx_idx[7:0] - 8'h01)])
		else $error("echo differs from request");
	a_reg_offset: assert property (q.st == mbs_pkg::ST_WRITE &&
		q.k == 18'h00000 && fc == mbs_pkg::FC_WR_REG |=>
		q.wofs == {adr[8:0], 1'b0} && q.wdat == rxf[mbs_pkg::POS_VAL])
		else $error("register at wrong offset");
endmodule // mbs_slave

// file: shared/mbs_pkg.sv
// Constants and types of the serial slave that serves the fieldbus buffers
package mbs_pkg;
	// Buffer sizes
	localparam int          BUF_BYTES   = 1024;
	localparam int          FRAME_BYTES = 256;
	localparam logic [17:0] BUF_LIMIT   = 18'h00400;
	localparam logic [17:0] COIL_LIMIT  = 18'h02000;
	localparam logic [17:0] LEN_MAX     = 18'h000FF;
	localparam logic [8:0]  RX_FULL     = 9'h100;
	localparam logic [8:0]  MIN_FRAME   = 9'h008;
	// Function codes
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_DISC  = 8'h02;
	localparam logic [7:0] FC_RD_HOLD  = 8'h03;
	localparam logic [7:0] FC_RD_INPUT = 8'h04;
	localparam logic [7:0] FC_WR_COIL  = 8'h05;
	localparam logic [7:0] FC_WR_REG   = 8'h06;
	localparam logic [7:0] FC_WR_COILS = 8'h0F;
	localparam logic [7:0] FC_WR_REGS  = 8'h10;
	// Exception answers
	localparam logic [7:0] EXC_FLAG     = 8'h80;
	localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
	// Coil value that switches a coil on
	localparam logic [15:0] COIL_ON = 16'hFF00;
	// Checksum
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	// Request byte positions
	localparam logic [7:0] POS_ID   = 8'h00;
	localparam logic [7:0] POS_FC   = 8'h01;
	localparam logic [7:0] POS_VAL  = 8'h04;
	localparam logic [7:0] POS_DATA = 8'h07;
	// Reply lengths before the checksum; the echo length includes it
	localparam logic [10:0] READ_HDR  = 11'h003;
	localparam logic [10:0] MULTI_HDR = 11'h006;
	localparam logic [10:0] EXC_LEN   = 11'h003;
	localparam logic [10:0] ECHO_LEN  = 11'h008;

	typedef enum logic [2:0] {
		ST_IDLE, ST_CHECK, ST_WRITE, ST_FBOUT, ST_TX
	} mbs_state_type;
	typedef enum logic [1:0] {RK_READ, RK_ECHO, RK_MULTI, RK_EXC}
		mbs_reply_type;
	typedef enum logic [1:0] {FI_IDLE, FI_LEN, FI_DATA} mbs_fbin_type;

	typedef struct packed {
		mbs_state_type st;
		mbs_reply_type kind;
		logic [7:0]    id;
		logic [8:0]    rx_cnt;
		logic [15:0]   crc;
		logic [17:0]   base;
		logic [17:0]   n;
		logic [10:0]   len;
		logic [7:0]    exc;
		logic [17:0]   k;
		logic          wen;
		logic [9:0]    wofs;
		logic [7:0]    wdat;
		logic [7:0]    out_len;
		logic [7:0]    trig;
		logic [10:0]   fbo_idx;
		mbs_fbin_type  fbi;
		logic [7:0]    fbi_left;
		logic [9:0]    fbi_idx;
		logic [10:0]   tx_idx;
		logic          tx_valid;
		logic [7:0]    tx_data;
		logic          fbo_valid;
		logic          fbo_first;
		logic [7:0]    fbo_data;
	} mbs_core_type;
endpackage

// file: design/mbs_crc16.sv
// One byte step of the frame checksum
`timescale 1ns/1ps
module mbs_crc16 (
	// Running value and next byte
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data_in,
	// Updated value
	output logic [15:0]      crc_out
);
	// Reflected shift, eight bits per byte
	always_comb begin
		crc_out = crc_in ^ {8'h00, data_in};
		for (int i = 0; i < 8; i++) begin
			if (crc_out[0])
				crc_out = (crc_out >> 1) ^ mbs_pkg::CRC_POLY;
			else
				crc_out = crc_out >> 1;
		end
	end
endmodule // mbs_crc16

// file: test/mbs_master_model.sv
// Serial master model: sends request frames and gathers reply bytes
`timescale 1ns/1ps
module mbs_master_model (
	// Clock and pacing
	input  wire logic       clk,
	input  wire logic       slow,
	// Request bytes toward the slave
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_frame_end,
	// Reply bytes from the slave
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] rsp[$];
	int         idle;

	// Idle line at time zero
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_frame_end = 1'b0;
		tx_ready = 1'b1;
		idle = 0;
	end

	// Standard reflected frame checksum
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	// Reply capture; slow pacing stalls every other cycle
	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready) begin
			rsp.push_back(tx_data);
			idle = 0;
		end else
			idle = idle + 1;
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	// Whole frame, checksum low byte first, then wait for the reply
	task automatic request(input logic [7:0] q[$]);
		logic [15:0] c;
		c = crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		rsp.delete();
		foreach (q[i]) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data  <= q[i];
		end
		@(posedge clk);
		rx_valid     <= 1'b0;
		rx_data      <= ~q[q.size()-1];
		rx_frame_end <= 1'b1;
		@(posedge clk);
		rx_frame_end <= 1'b0;
		repeat (600) begin
			@(posedge clk);
			if (rsp.size() > 0 && idle > 8)
				break;
		end
	endtask
endmodule // mbs_master_model

// file: test/modbus_slave_buffer_map_bench.sv
// Self-checking bench of the serial slave with its fieldbus buffers
`timescale 1ns/1ps
module modbus_slave_buffer_map_bench;
	logic       CORE_CLK, RSTN, TRIG_MODE, slow;
	logic [3:0] sw_hi, sw_lo;
	logic       RX_VALID, RX_FRAME_END, TX_VALID, TX_READY;
	logic [7:0] RX_DATA, TX_DATA, FB_IN_DATA, FB_OUT_DATA;
	logic       FB_IN_VALID, FB_IN_FIRST, FB_OUT_VALID, FB_OUT_FIRST;
	logic [7:0] fbq[$];
	int         n_errors, checked;

	mbs_slave u_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
		.ID_SW_HIGH(sw_hi), .ID_SW_LOW(sw_lo), .TRIG_MODE(TRIG_MODE),
		.RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
		.RX_FRAME_END(RX_FRAME_END), .TX_VALID(TX_VALID),
		.TX_DATA(TX_DATA), .TX_READY(TX_READY),
		.FB_IN_VALID(FB_IN_VALID), .FB_IN_FIRST(FB_IN_FIRST),
		.FB_IN_DATA(FB_IN_DATA), .FB_OUT_VALID(FB_OUT_VALID),
		.FB_OUT_FIRST(FB_OUT_FIRST), .FB_OUT_DATA(FB_OUT_DATA));

	mbs_master_model u_mst (.clk(CORE_CLK), .slow(slow),
		.rx_valid(RX_VALID), .rx_data(RX_DATA),
		.rx_frame_end(RX_FRAME_END), .tx_valid(TX_VALID),
		.tx_data(TX_DATA), .tx_ready(TX_READY));

	// Clock of 10 ns
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// Fieldbus output telegram capture
	always @(posedge CORE_CLK)
		if (FB_OUT_VALID === 1'b1) begin
			if (FB_OUT_FIRST === 1'b1)
				fbq.delete();
			fbq.push_back(FB_OUT_DATA);
		end

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Request, then compare the reply and its checksum
	task automatic txn(input logic [7:0] q[$], input logic [7:0] e[$]);
		logic [15:0] c;
		u_mst.request(q);
		c = u_mst.crc16(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		chk("reply length", 8'(e.size()), 8'(u_mst.rsp.size()));
		foreach (e[i])
			chk("reply byte", e[i], u_mst.rsp[i]);
	endtask

	task automatic fb_send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge CORE_CLK);
			FB_IN_VALID <= 1'b1;
			FB_IN_FIRST <= (i == 0);
			FB_IN_DATA  <= q[i];
		end
		@(posedge CORE_CLK);
		FB_IN_VALID <= 1'b0;
		FB_IN_DATA  <= ~q[q.size()-1];
	endtask

	task automatic t_fb_in();
		fb_send('{8'h04, 8'hA1, 8'hA2, 8'hA3, 8'hA4});
		fb_send('{8'h03, 8'hB1, 8'hB2, 8'hB3, 8'hC4});
		txn('{8'h17, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02},
			'{8'h17, 8'h04, 8'h04, 8'hB1, 8'hB2, 8'hB3, 8'hA4});
		txn('{8'h17, 8'h02, 8'h00, 8'h00, 8'h00, 8'h0C},
			'{8'h17, 8'h02, 8'h02, 8'hB1, 8'h02});
		txn('{8'h17, 8'h02, 8'h00, 8'h04, 8'h00, 8'h08},
			'{8'h17, 8'h02, 8'h01, 8'h2B});
	endtask

	task automatic t_reg();
		chk("idle output", 8'h00, 8'(fbq.size()));
		txn('{8'h17, 8'h06, 8'h00, 8'h07, 8'h12, 8'h34},
			'{8'h17, 8'h06, 8'h00, 8'h07, 8'h12, 8'h34});
		chk("out length", 8'h10, fbq[0]);
		chk("out byte 14", 8'h12, fbq[15]);
		chk("out byte 15", 8'h34, fbq[16]);
		fbq.delete();
		txn('{8'h17, 8'h03, 8'h00, 8'h07, 8'h00, 8'h01},
			'{8'h17, 8'h03, 8'h02, 8'h12, 8'h34});
		chk("read no output", 8'h00, 8'(fbq.size()));
	endtask

	task automatic t_coil();
		slow = 1'b1;
		txn('{8'h17, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h10, 8'h02, 8'h0E,
			8'h81}, '{8'h17, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h10});
		chk("coil byte 0", 8'h0E, fbq[1]);
		chk("coil byte 1", 8'h81, fbq[2]);
		txn('{8'h17, 8'h05, 8'h00, 8'h0C, 8'hFF, 8'h00},
			'{8'h17, 8'h05, 8'h00, 8'h0C, 8'hFF, 8'h00});
		txn('{8'h17, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10},
			'{8'h17, 8'h01, 8'h02, 8'h0E, 8'h91});
		txn('{8'h17, 8'h05, 8'h00, 8'h0C, 8'h00, 8'h00},
			'{8'h17, 8'h05, 8'h00, 8'h0C, 8'h00, 8'h00});
		txn('{8'h17, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10},
			'{8'h17, 8'h01, 8'h02, 8'h0E, 8'h81});
		slow = 1'b0;
	endtask

	task automatic t_multi();
		txn('{8'h17, 8'h10, 8'h00, 8'h04, 8'h00, 8'h04, 8'h08, 8'h11,
			8'h11, 8'h22, 8'h22, 8'h33, 8'h33, 8'h44, 8'h44},
			'{8'h17, 8'h10, 8'h00, 8'h04, 8'h00, 8'h04});
		txn('{8'h17, 8'h10, 8'h00, 8'h05, 8'h00, 8'h02, 8'h04, 8'hAA,
			8'hBB, 8'hCC, 8'hDD},
			'{8'h17, 8'h10, 8'h00, 8'h05, 8'h00, 8'h02});
		txn('{8'h17, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04},
			'{8'h17, 8'h03, 8'h08, 8'h11, 8'h11, 8'hAA, 8'hBB, 8'hCC,
			8'hDD, 8'h44, 8'h44});
	endtask

	task automatic t_limit();
		txn('{8'h17, 8'h06, 8'h01, 8'hFF, 8'h5A, 8'hA5},
			'{8'h17, 8'h06, 8'h01, 8'hFF, 8'h5A, 8'hA5});
		chk("saturated length", 8'hFF, fbq[0]);
		txn('{8'h17, 8'h03, 8'h01, 8'hFF, 8'h00, 8'h01},
			'{8'h17, 8'h03, 8'h02, 8'h5A, 8'hA5});
		txn('{8'h17, 8'h03, 8'h02, 8'h00, 8'h00, 8'h01},
			'{8'h17, 8'h83, 8'h02});
		txn('{8'h17, 8'h03, 8'h01, 8'hFF, 8'h00, 8'h01},
			'{8'h17, 8'h03, 8'h02, 8'h5A, 8'hA5});
		txn('{8'h17, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01},
			'{8'h17, 8'h87, 8'h01});
	endtask

	task automatic t_addr();
		sw_hi <= 4'h2;
		sw_lo <= 4'h3;
		u_mst.request('{8'h17, 8'h03, 8'h00, 8'h07, 8'h00, 8'h01});
		chk("foreign reply", 8'h00, 8'(u_mst.rsp.size()));
		txn('{8'h23, 8'h03, 8'h00, 8'h07, 8'h00, 8'h01},
			'{8'h23, 8'h03, 8'h02, 8'h44, 8'h44});
	endtask

	task automatic t_trig();
		TRIG_MODE <= 1'b1;
		txn('{8'h23, 8'h06, 8'h00, 8'h00, 8'h01, 8'h02},
			'{8'h23, 8'h06, 8'h00, 8'h00, 8'h01, 8'h02});
		chk("trigger first", 8'h01, fbq[0]);
		chk("trig length", 8'hFF, fbq[1]);
		chk("trig data", 8'h01, fbq[2]);
		txn('{8'h23, 8'h06, 8'h00, 8'h00, 8'h01, 8'h02},
			'{8'h23, 8'h06, 8'h00, 8'h00, 8'h01, 8'h02});
		chk("trigger step", 8'h02, fbq[0]);
		fb_send('{8'h09, 8'h02, 8'hC1, 8'hC2, 8'hC3});
		txn('{8'h23, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02},
			'{8'h23, 8'h04, 8'h04, 8'hC1, 8'hC2, 8'hB3, 8'hA4});
	endtask

	task automatic conclude();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge CORE_CLK);
		n_errors++;
		conclude();
	end

	// Reset, then the scenarios in order
	initial begin
		RSTN = 1'b0;
		TRIG_MODE = 1'b0;
		slow = 1'b0;
		sw_hi = 4'h1;
		sw_lo = 4'h7;
		FB_IN_VALID = 1'b0;
		FB_IN_FIRST = 1'b0;
		FB_IN_DATA = 8'h00;
		n_errors = 0;
		checked = 0;
		repeat (4) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		t_fb_in();
		t_reg();
		t_coil();
		t_multi();
		t_limit();
		t_addr();
		t_trig();
		conclude();
	end
endmodule // modbus_slave_buffer_map_bench
